// File: rtl/gdsp_spi_port.v
// Purpose: 16-bit SPI slave command port of a dual stepper-gauge driver
// Assumes: pins are asynchronous to core_clk and oversampled; motion logic lives outside
// Notes: registers are write-only; device state is read only through the status word
`timescale 1ns/1ps
`include "gdsp_defines.vh"

// How it works
// - serial input is shifted in on each falling serial clock while select is low.
// - serial output changes only on rising serial clock edges.
// - on select rising, the word goes to the register its top bits address.
// - first rising clock of a frame loads the status word; it leaves first.
// - clocking past sixteen bits returns the earlier received bits in order.
// - frames shorter than sixteen or not a multiple of sixteen change nothing.
// - words travel most significant bit first on both lines.
// - address decode: power, velocity, two positions, return-to-zero, its config.
// - power register bits zero and one enable gauge zero and gauge one drivers.
// - both enables zero puts the device in standby; oscillator keeps running.
// - calibration bit starts measuring one reference low pulse on select.
// - calibration is accepted only when both gauges are off or both still.
// - frequency select bit trims below nominal or centred on nominal.
// - slowdown bit slows the oscillator by a third; a 12 us pulse matches.
// - null bit set means the power write changes nothing at all.
// - velocity index one to 255 stays the selected gauge ceiling until rewritten.
// - an index above the table top is replaced by the table top.
// - a lower ceiling waits until the motor has slowed to it.
// - velocity apply bits pick gauge zero, gauge one, or both.
// - while select is high, clock and input are ignored and output is released.
module gdsp_spi_port #(
	parameter VEL_W = 8,
	parameter [VEL_W-1:0] VEL_TABLE_TOP = `GDSP_VEL_TABLE_TOP,
	parameter PER_W = 12
) (
	input wire core_clk,
	input wire rst_n,
	input wire cs_n,
	input wire sclk,
	input wire si,
	output reg so,
	output reg so_oe,
	input wire [15:0] status_word,
	input wire [VEL_W-1:0] gauge0_speed,
	input wire [VEL_W-1:0] gauge1_speed,
	output reg gauge_zero_drive_enable,
	output reg gauge_one_drive_enable,
	output reg standby,
	output reg cal_frequency_select,
	output reg oscillator_slowdown,
	output reg [VEL_W-1:0] gauge0_velocity_ceiling,
	output reg [VEL_W-1:0] gauge1_velocity_ceiling,
	output reg reg_wr_stb,
	output reg [2:0] reg_wr_addr,
	output reg [`GDSP_DATA_W-1:0] reg_wr_data,
	output wire calibration_fault_flag,
	output wire osc_tick,
	output wire [PER_W-1:0] osc_period
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// clamp a written index to the top of the acceleration table
	function [VEL_W-1:0] vel_clamp;
		input [VEL_W-1:0] idx;
		begin
			vel_clamp = (idx > VEL_TABLE_TOP) ? VEL_TABLE_TOP : idx;
		end
	endfunction

	// a pending ceiling may take over once the motor is at or below it
	function vel_ready;
		input [VEL_W-1:0] speed;
		input [VEL_W-1:0] ceiling;
		begin
			vel_ready = (speed <= ceiling);
		end
	endfunction

	// ****************************************************************
	// pin synchronisation and edge detection
	// ****************************************************************
	wire [2:0] pins_s;
	wire cs_s;
	wire sclk_s;
	wire si_s;
	reg cs_p_q;
	reg sclk_p_q;

	gdsp_sync #(
		.WIDTH(3),
		.RESET_VAL(3'h4)
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in({cs_n, sclk, si}),
		.sync_out(pins_s)
	);

	assign cs_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign si_s = pins_s[0];

	// previous samples for edge finding
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_p_q <= 1'b1;
			sclk_p_q <= 1'b0;
		end else begin
			cs_p_q <= cs_s;
			sclk_p_q <= sclk_s;
		end
	end

	// clock edges count only while select is low
	wire sclk_rise = sclk_s & ~sclk_p_q & ~cs_s;
	wire sclk_fall = ~sclk_s & sclk_p_q & ~cs_s;
	wire cs_fall = ~cs_s & cs_p_q;
	wire cs_rise = cs_s & ~cs_p_q;

	// ****************************************************************
	// shift registers
	// ****************************************************************
	reg [15:0] in_sh_q;
	reg [3:0] bit_cnt_q;
	reg full_q;
	reg first_q;
	reg last_si_q;
	reg [15:0] out_sh_q;
	wire [15:0] status_out;

	// status word with our own calibration fault in its slot
	assign status_out = {status_word[15:`GDSP_ST_CAL_FAULT+1], calibration_fault_flag,
		status_word[`GDSP_ST_CAL_FAULT-1:0]};

	// capture on falling clock, count bits modulo sixteen
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_sh_q <= 16'h0000;
			bit_cnt_q <= 4'h0;
			full_q <= 1'b0;
			last_si_q <= 1'b0;
		end else if (cs_fall) begin
			bit_cnt_q <= 4'h0;
			full_q <= 1'b0;
		end else if (sclk_fall) begin
			// first bit in ends up at the top
			in_sh_q <= {in_sh_q[14:0], si_s};
			last_si_q <= si_s;
			bit_cnt_q <= bit_cnt_q + 4'h1;
			if (bit_cnt_q == 4'hF)
				full_q <= 1'b1;
		end
	end

	// output shifter and pin drive
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_sh_q <= 16'h0000;
			first_q <= 1'b0;
			so <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			if (cs_fall) begin
				first_q <= 1'b1;
				so_oe <= 1'b1;
			end else if (cs_rise) begin
				// release the output outside a frame
				so_oe <= 1'b0;
				first_q <= 1'b0;
			end
			if (sclk_rise) begin
				first_q <= 1'b0;
				if (first_q) begin
					out_sh_q <= status_out;
					// output moves on the rising edge only
					so <= status_out[15];
				end else begin
					// earlier input bits follow sixteen clocks later
					out_sh_q <= {out_sh_q[14:0], last_si_q};
					so <= out_sh_q[14];
				end
			end
		end
	end

	// ****************************************************************
	// frame decode
	// ****************************************************************
	wire [2:0] w_addr = in_sh_q[`GDSP_ADDR_HI:`GDSP_ADDR_LO];
	wire [`GDSP_DATA_W-1:0] w_data = in_sh_q[`GDSP_DATA_W-1:0];
	// only whole multiples of sixteen bits commit
	wire commit = cs_rise & full_q & (bit_cnt_q == 4'h0);
	wire moving_a = status_word[`GDSP_ST_MOTION_A];
	wire moving_b = status_word[`GDSP_ST_MOTION_B];
	reg wr_pe;
	reg wr_vel;
	reg wr_ext;

	always @* begin
		wr_pe = 1'b0;
		wr_vel = 1'b0;
		wr_ext = 1'b0;
		if (commit) begin
			case (w_addr)
				`GDSP_ADR_PWR_EN_CAL: begin
					wr_pe = ~w_data[`GDSP_PE_NULL] & ((w_data & `GDSP_PE_ZERO_MASK) == 13'h0000);
				end
				`GDSP_ADR_MAX_VEL: begin
					// spare bits must be zero and the index nonzero
					wr_vel = ((w_data & `GDSP_VEL_ZERO_MASK) == 13'h0000) &
						(w_data[VEL_W-1:0] != {VEL_W{1'b0}});
				end
				`GDSP_ADR_POS0, `GDSP_ADR_POS1: begin
					wr_ext = ((w_data & `GDSP_POS_ZERO_MASK) == 13'h0000);
				end
				`GDSP_ADR_RTZ_CTRL: begin
					wr_ext = ((w_data & `GDSP_RTZ_ZERO_MASK) == 13'h0000);
				end
				`GDSP_ADR_RTZ_CFG: begin
					wr_ext = 1'b1;
				end
				// unused and test addresses are dropped
				default: begin
					wr_ext = 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// power, enable and calibration register
	// ****************************************************************
	reg cal_arm_q;

	// load the addressed register on select rising
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gauge_zero_drive_enable <= 1'b0;
			gauge_one_drive_enable <= 1'b0;
			standby <= 1'b1;
			cal_frequency_select <= 1'b0;
			oscillator_slowdown <= 1'b0;
			cal_arm_q <= 1'b0;
		end else begin
			cal_arm_q <= 1'b0;
			if (wr_pe) begin
				gauge_zero_drive_enable <= w_data[`GDSP_PE_GAUGE0_EN];
				gauge_one_drive_enable <= w_data[`GDSP_PE_GAUGE1_EN];
				standby <= ~w_data[`GDSP_PE_GAUGE0_EN] & ~w_data[`GDSP_PE_GAUGE1_EN];
				oscillator_slowdown <= w_data[`GDSP_PE_SLOWDOWN];
				cal_frequency_select <= w_data[`GDSP_PE_CAL_FSEL];
				// calibration only when idle or disabled
				cal_arm_q <= w_data[`GDSP_PE_CAL_START] &
					((~gauge_zero_drive_enable & ~gauge_one_drive_enable) |
					(~moving_a & ~moving_b));
			end
		end
	end

	gdsp_osc_cal #(
		.PER_W(PER_W),
		.CNT_W(16)
	) u_osc (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cs_n_s(cs_s),
		.cal_arm(cal_arm_q),
		.cal_frequency_select(cal_frequency_select),
		.oscillator_slowdown(oscillator_slowdown),
		.calibration_fault_flag(calibration_fault_flag),
		.osc_tick(osc_tick),
		.osc_period(osc_period)
	);

	// ****************************************************************
	// maximum velocity register
	// ****************************************************************
	reg [VEL_W-1:0] pend0_q;
	reg [VEL_W-1:0] pend1_q;
	reg pend0_v_q;
	reg pend1_v_q;
	wire [VEL_W-1:0] new_ceil = vel_clamp(w_data[VEL_W-1:0]);

	// ceiling held until rewritten, pending copy per gauge
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend0_q <= `GDSP_VEL_RESET;
			pend1_q <= `GDSP_VEL_RESET;
			pend0_v_q <= 1'b0;
			pend1_v_q <= 1'b0;
			gauge0_velocity_ceiling <= `GDSP_VEL_RESET;
			gauge1_velocity_ceiling <= `GDSP_VEL_RESET;
		end else begin
			// a lower ceiling waits for the motor to slow
			if (pend0_v_q && vel_ready(gauge0_speed, pend0_q)) begin
				gauge0_velocity_ceiling <= pend0_q;
				pend0_v_q <= 1'b0;
			end
			if (pend1_v_q && vel_ready(gauge1_speed, pend1_q)) begin
				gauge1_velocity_ceiling <= pend1_q;
				pend1_v_q <= 1'b0;
			end
			if (wr_vel && w_data[`GDSP_VEL_APPLY0]) begin
				// index clamped to the table top
				pend0_q <= new_ceil;
				pend0_v_q <= 1'b1;
			end
			if (wr_vel && w_data[`GDSP_VEL_APPLY1]) begin
				pend1_q <= new_ceil;
				pend1_v_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// hand-off of position and return-to-zero writes
	// ****************************************************************

	// write-only hand-off; nothing here is read back
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_wr_stb <= 1'b0;
			reg_wr_addr <= 3'h0;
			reg_wr_data <= 13'h0000;
		end else begin
			reg_wr_stb <= wr_ext;
			if (wr_ext) begin
				reg_wr_addr <= w_addr;
				reg_wr_data <= w_data;
			end
		end
	end

endmodule // gdsp_spi_port

// File: rtl/gdsp_defines.vh
// Purpose: shared offsets, field positions, reset values and timing for the gauge SPI port
// Assumes: core clock of 200 MHz, 16-bit frames, three-bit address in the top bits
// Notes: times are kept in their own unit; cycle counts are derived from them
`ifndef GDSP_DEFINES_VH
`define GDSP_DEFINES_VH

// ****************************************************************
// frame layout
// ****************************************************************
`define GDSP_WORD_W 16
`define GDSP_ADDR_HI 15
`define GDSP_ADDR_LO 13
`define GDSP_DATA_W 13

// ****************************************************************
// register addresses
// ****************************************************************
`define GDSP_ADR_PWR_EN_CAL 3'h0
`define GDSP_ADR_MAX_VEL 3'h1
`define GDSP_ADR_POS0 3'h2
`define GDSP_ADR_POS1 3'h3
`define GDSP_ADR_RTZ_CTRL 3'h4
`define GDSP_ADR_RTZ_CFG 3'h5

// ****************************************************************
// power, enable and calibration fields
// ****************************************************************
`define GDSP_PE_GAUGE0_EN 0
`define GDSP_PE_GAUGE1_EN 1
`define GDSP_PE_SLOWDOWN 2
`define GDSP_PE_CAL_START 3
`define GDSP_PE_CAL_FSEL 4
`define GDSP_PE_NULL 12
`define GDSP_PE_ZERO_MASK 13'h0FE0

// ****************************************************************
// velocity, position and return-to-zero fields
// ****************************************************************
`define GDSP_VEL_APPLY0 8
`define GDSP_VEL_APPLY1 9
`define GDSP_VEL_ZERO_MASK 13'h1C00
`define GDSP_POS_ZERO_MASK 13'h1000
`define GDSP_RTZ_ZERO_MASK 13'h1FE0
`define GDSP_VEL_TABLE_TOP 8'hFF
`define GDSP_VEL_RESET 8'hFF

// ****************************************************************
// status word bits
// ****************************************************************
`define GDSP_ST_MOTION_A 4
`define GDSP_ST_MOTION_B 5
`define GDSP_ST_CAL_FAULT 7

// ****************************************************************
// timing
// ****************************************************************
`define GDSP_CLK_PERIOD_PS 5000
`define GDSP_OSC_NOM_NS 1000
`define GDSP_OSC_NOM_CYC ((`GDSP_OSC_NOM_NS * 1000) / `GDSP_CLK_PERIOD_PS)
`define GDSP_CAL_REF_NS 8000
`define GDSP_CAL_SLOW_REF_NS 12000
`define GDSP_CAL_DIV 8
`define GDSP_CAL_SLOW_DIV 12
`define GDSP_CAL_TOL_DIV 4

`endif

// File: rtl/gdsp_sync.v
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to core_clk
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps

module gdsp_sync #(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire core_clk,
	input wire rst_n,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;

	// two flops in series, constant reset values
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // gdsp_sync

// File: rtl/gdsp_osc_cal.v
// Purpose: calibratable internal oscillator tick and reference-pulse measurement
// Assumes: chip select arrives already synchronised; cal_arm is a one-cycle pulse
// Notes: the oscillator keeps ticking in standby; a faulty measurement keeps the old trim
`timescale 1ns/1ps
`include "gdsp_defines.vh"

module gdsp_osc_cal #(
	parameter PER_W = 12,
	parameter CNT_W = 16
) (
	input wire core_clk,
	input wire rst_n,
	input wire cs_n_s,
	input wire cal_arm,
	input wire cal_frequency_select,
	input wire oscillator_slowdown,
	output reg calibration_fault_flag,
	output reg osc_tick,
	output reg [PER_W-1:0] osc_period
);

	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_ARMED = 3'h2;
	localparam [2:0] ST_MEASURE = 3'h4;
	localparam integer NOM_INT = `GDSP_OSC_NOM_CYC;
	localparam integer TOL_INT = `GDSP_OSC_NOM_CYC / `GDSP_CAL_TOL_DIV;
	localparam integer DIV_INT = `GDSP_CAL_DIV;
	localparam integer SLOW_DIV_INT = `GDSP_CAL_SLOW_DIV;
	// sized copies so the divider and compares keep their own widths
	localparam [PER_W-1:0] NOM_PER = NOM_INT[PER_W-1:0];
	localparam [PER_W-1:0] TOL = TOL_INT[PER_W-1:0];
	localparam [CNT_W-1:0] DIV_N = DIV_INT[CNT_W-1:0];
	localparam [CNT_W-1:0] SLOW_DIV_N = SLOW_DIV_INT[CNT_W-1:0];

	reg [2:0] state_q;
	reg [CNT_W-1:0] meas_q;
	reg [PER_W-1:0] base_q;
	reg slow_meas_q;
	reg below_q;
	reg [PER_W-1:0] div_q;
	reg [CNT_W-1:0] raw_base;
	reg [CNT_W-1:0] trim_base;
	reg [PER_W-1:0] eff_per;

	// base period from the measured pulse; below-target mode adds an eighth
	always @* begin
		raw_base = slow_meas_q ? (meas_q / SLOW_DIV_N) : (meas_q / DIV_N);
		trim_base = below_q ? (raw_base + (raw_base >> 3)) : raw_base;
		eff_per = oscillator_slowdown ? (base_q + (base_q >> 1)) : base_q;
	end

	// measure the reference low pulse on chip select
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			meas_q <= {CNT_W{1'b0}};
			base_q <= NOM_PER;
			slow_meas_q <= 1'b0;
			below_q <= 1'b0;
			calibration_fault_flag <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (cal_arm) begin
						state_q <= ST_ARMED;
						slow_meas_q <= oscillator_slowdown;
						below_q <= ~cal_frequency_select;
					end
				end
				ST_ARMED: begin
					if (!cs_n_s) begin
						state_q <= ST_MEASURE;
						meas_q <= {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
				ST_MEASURE: begin
					if (!cs_n_s) begin
						if (meas_q != {CNT_W{1'b1}})
							meas_q <= meas_q + 1'b1;
					end else begin
						state_q <= ST_IDLE;
						// a matching 12 us pulse under slowdown is no fault
						if (raw_base < {{(CNT_W-PER_W){1'b0}}, NOM_PER - TOL} ||
							raw_base > {{(CNT_W-PER_W){1'b0}}, NOM_PER + TOL}) begin
							calibration_fault_flag <= 1'b1;
						end else begin
							calibration_fault_flag <= 1'b0;
							// trim below or centred on the nominal rate
							base_q <= trim_base[PER_W-1:0];
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// oscillator divider runs in every power state
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= {PER_W{1'b0}};
			osc_tick <= 1'b0;
			osc_period <= NOM_PER;
		end else begin
			osc_period <= eff_per;
			if (div_q + 1'b1 >= eff_per) begin
				div_q <= {PER_W{1'b0}};
				osc_tick <= 1'b1;
			end else begin
				div_q <= div_q + 1'b1;
				osc_tick <= 1'b0;
			end
		end
	end

endmodule // gdsp_osc_cal

// File: test/gdsp_checker.sv
// Purpose: pin and register timing assertions for the gauge SPI port
// Assumes: bound to gdsp_spi_port; one core clock domain
// Notes: figures allow for the two-flop pin synchroniser
`timescale 1ns/1ps

module gdsp_checker #(
	parameter VEL_W = 8
) (
	input wire core_clk,
	input wire rst_n,
	input wire cs_n,
	input wire sclk,
	input wire so,
	input wire so_oe,
	input wire [VEL_W-1:0] gauge0_speed,
	input wire [VEL_W-1:0] gauge0_velocity_ceiling,
	input wire gauge_zero_drive_enable,
	input wire gauge_one_drive_enable,
	input wire standby,
	input wire reg_wr_stb,
	input wire [2:0] reg_wr_addr,
	input wire calibration_fault_flag,
	input wire osc_tick
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_oe_off; cs_n[*6] |-> !so_oe; endproperty
	property p_oe_on; (!cs_n)[*6] |-> so_oe; endproperty
	property p_so_hold; (!sclk && !cs_n)[*8] |-> $stable(so); endproperty
	property p_stb_pulse; reg_wr_stb |=> !reg_wr_stb; endproperty
	property p_stb_addr; reg_wr_stb |-> reg_wr_addr inside {3'h2, 3'h3, 3'h4, 3'h5}; endproperty
	property p_stb_cs; reg_wr_stb |-> cs_n && !$past(cs_n, 8); endproperty
	property p_en_cs;
		$changed(gauge_zero_drive_enable) || $changed(gauge_one_drive_enable)
			|-> cs_n && $past(cs_n, 2);
	endproperty
	property p_standby; standby == (!gauge_zero_drive_enable && !gauge_one_drive_enable); endproperty
	property p_ceil;
		$changed(gauge0_velocity_ceiling) |-> $past(gauge0_speed) <= gauge0_velocity_ceiling;
	endproperty
	property p_fault_cs; $changed(calibration_fault_flag) |-> cs_n; endproperty
	property p_osc; osc_tick |=> (!osc_tick)[*8] ##[1:400] osc_tick; endproperty

	a_oe_off: assert property (p_oe_off) else $error("so_oe high with select idle");
	a_oe_on: assert property (p_oe_on) else $error("so_oe low inside a frame");
	a_so_hold: assert property (p_so_hold) else $error("so moved without a clock rise");
	a_stb_pulse: assert property (p_stb_pulse) else $error("write strobe too long");
	a_stb_addr: assert property (p_stb_addr) else $error("write strobe to bad address");
	a_stb_cs: assert property (p_stb_cs) else $error("write strobe not after select rise");
	a_en_cs: assert property (p_en_cs) else $error("enable moved inside a frame");
	a_standby: assert property (p_standby) else $error("standby disagrees with enables");
	a_ceil: assert property (p_ceil) else $error("ceiling below current speed");
	a_fault_cs: assert property (p_fault_cs) else $error("fault flag moved inside pulse");
	a_osc: assert property (p_osc) else $error("oscillator tick stopped");

	c_stb: cover property (reg_wr_stb);
	c_fault: cover property ($rose(calibration_fault_flag));
	c_ceil: cover property ($changed(gauge0_velocity_ceiling));
endmodule // gdsp_checker

// File: test/gdsp_master_model.sv
// Purpose: microcontroller SPI master driving the gauge port pins
// Assumes: driven off the falling core clock edge
// Notes: sclk and si rest low, as their pull-downs would leave them
`timescale 1ns/1ps

module gdsp_master_model (
	input wire core_clk,
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire so_w
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// clocks only inside select, msb first
	task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
		rx = '0;
		cs_n = 1'b0;
		wait_clk(6);
		for (int i = 0; i < n; i++) begin
			si = tx[47-i];
			wait_clk(6);
			sclk = 1'b1;
			wait_clk(12);
			sclk = 1'b0;
			rx[47-i] = so_w;
			wait_clk(7);
		end
		si = 1'b0;
		cs_n = 1'b1;
		// select held high for the internal transfer
		wait_clk(20);
	endtask

	// reference low pulse on select only
	task automatic cal_pulse(input int cyc);
		cs_n = 1'b0;
		wait_clk(cyc);
		cs_n = 1'b1;
		wait_clk(40);
	endtask
endmodule // gdsp_master_model

// File: test/gdsp_spi_port_bench.sv
// Purpose: self-checking bench for the gauge SPI port
// Assumes: table top set to C0 so clamping shows
// Notes: expected status is rebuilt from bench-held fault state
`timescale 1ns/1ps

module gdsp_spi_port_bench;
	localparam [7:0] TOP = 8'hC0;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] status_word = 16'hA54A;
	logic [7:0] gauge0_speed = 8'h10;
	logic [7:0] gauge1_speed = 8'h10;
	wire cs_n, sclk, si, so, so_oe, standby, cal_frequency_select, oscillator_slowdown;
	wire gauge_zero_drive_enable, gauge_one_drive_enable, reg_wr_stb, calibration_fault_flag;
	wire osc_tick;
	wire [7:0] gauge0_velocity_ceiling, gauge1_velocity_ceiling;
	wire [2:0] reg_wr_addr;
	wire [12:0] reg_wr_data;
	wire [11:0] osc_period;
	wire so_w = so_oe ? so : 1'bz;
	int miscompares = 0;
	int checks = 0;
	int wr_cnt = 0;
	logic exp_fault = 1'b0;
	logic [15:0] last_wr;
	logic [47:0] rx;
	logic [15:0] bad[6] = '{16'h1000, 16'h0020, 16'hC003, 16'hE003, 16'h2540, 16'h2100};
	logic [15:0] cal_w[4] = '{16'h0008, 16'h0018, 16'h001C, 16'h0018};
	int cal_len[4] = '{1600, 1600, 2400, 800};
	logic [12:0] cal_exp[4] = '{13'h00E1, 13'h00C8, 13'h012C, 13'h10C8};

	always #2.5 core_clk = ~core_clk;

	gdsp_spi_port #(.VEL_TABLE_TOP(TOP)) dut (.core_clk, .rst_n, .cs_n, .sclk, .si, .so,
		.so_oe, .status_word, .gauge0_speed, .gauge1_speed, .gauge_zero_drive_enable,
		.gauge_one_drive_enable, .standby, .cal_frequency_select, .oscillator_slowdown,
		.gauge0_velocity_ceiling, .gauge1_velocity_ceiling, .reg_wr_stb, .reg_wr_addr,
		.reg_wr_data, .calibration_fault_flag, .osc_tick, .osc_period);

	gdsp_master_model m (.core_clk, .cs_n, .sclk, .si, .so_w);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// record forwarded writes
	always @(posedge core_clk) begin
		if (reg_wr_stb === 1'b1) begin
			wr_cnt++;
			last_wr = {reg_wr_addr, reg_wr_data};
		end
	end

	function automatic logic [15:0] exp_st();
		return {status_word[15:8], exp_fault, status_word[6:0]};
	endfunction

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] w);
		m.xfer(16, {w, 32'h0}, rx);
	endtask

	task automatic summarize();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// watchdog: tests need about 19k cycles, give up after 50k
	initial begin
		#250000;
		miscompares++;
		summarize();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		m.wait_clk(12);
		rst_n = 1'b1;
		m.wait_clk(4);
		chk({gauge_zero_drive_enable, gauge_one_drive_enable, standby}, 3'b001);
		chk({calibration_fault_flag, gauge0_velocity_ceiling, osc_period}, 21'h0FF0C8);
		$display("test reset done");
		wr(16'h0003);
		chk(rx[47:32], exp_st());
		chk({gauge_zero_drive_enable, gauge_one_drive_enable, standby}, 3'b110);
		for (int n = 15; n <= 17; n += 2) begin
			m.xfer(n, 48'h0, rx);
			chk({gauge_zero_drive_enable, gauge_one_drive_enable}, 2'b11);
		end
		m.xfer(32, {16'h4ABC, 16'h0001, 16'h0}, rx);
		chk(rx[31:16], 16'h4ABC);
		chk({gauge_zero_drive_enable, gauge_one_drive_enable, standby}, 3'b100);
		$display("test frames done");
		for (int i = 0; i < 6; i++) begin
			wr(bad[i]);
			chk({gauge_zero_drive_enable, gauge0_velocity_ceiling, wr_cnt[3:0]}, 13'h1FF0);
		end
		$display("test drops done");
		for (int a = 2; a <= 5; a++) begin
			wr({a[2:0], 13'h0010 + 13'(a)});
			chk({last_wr, wr_cnt[3:0]}, {a[2:0], 13'h0010 + 13'(a), 4'(a - 1)});
		end
		$display("test forward done");
		wr(16'h2140);
		chk({gauge0_velocity_ceiling, gauge1_velocity_ceiling}, 16'h40FF);
		gauge0_speed = 8'h80;
		wr(16'h2320);
		chk({gauge0_velocity_ceiling, gauge1_velocity_ceiling}, 16'h4020);
		gauge0_speed = 8'h10;
		m.wait_clk(5);
		chk(gauge0_velocity_ceiling, 8'h20);
		wr(16'h22F0);
		chk({gauge0_velocity_ceiling, gauge1_velocity_ceiling}, {8'h20, TOP});
		$display("test velocity done");
		wr(16'h0000);
		chk({gauge_zero_drive_enable, gauge_one_drive_enable, standby}, 3'b001);
		for (int i = 0; i < 4; i++) begin
			wr(cal_w[i]);
			m.cal_pulse(cal_len[i]);
			exp_fault = cal_exp[i][12];
			chk({cal_frequency_select, oscillator_slowdown}, cal_w[i][4:3] ^ {1'b0, cal_w[i][2] ^ 1'b1});
			chk({calibration_fault_flag, osc_period}, cal_exp[i]);
		end
		wr(16'h1000);
		chk(rx[47:32], exp_st());
		wr(16'h0003);
		status_word = 16'hA57A;
		wr(16'h0018);
		m.cal_pulse(1600);
		chk({calibration_fault_flag, osc_period}, 13'h10C8);
		$display("test calibration done");
		summarize();
	end
endmodule // gdsp_spi_port_bench

bind gdsp_spi_port gdsp_checker #(.VEL_W(VEL_W)) u_chk (.core_clk, .rst_n, .cs_n, .sclk, .so,
	.so_oe, .gauge0_speed, .gauge0_velocity_ceiling, .gauge_zero_drive_enable,
	.gauge_one_drive_enable, .standby, .reg_wr_stb, .reg_wr_addr, .calibration_fault_flag,
	.osc_tick);
